//--- verilog/adsr_envelope_generator.sv
`timescale 1ns/1ps
module adsr_envelope_generator #(
  parameter int TIME_DIV = 1
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [adsr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [adsr_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [adsr_pkg::DATA_W-1:0] reg_rdata,
  output logic [adsr_pkg::LEVEL_W-1:0] env_level,
  output adsr_pkg::adsr_phase_t env_phase
);
  import adsr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // registers
  adsr_settings_t settings;
  logic key;
  logic key_prev;
  adsr_phase_t state;
  adsr_phase_t next_state;
  logic [LEVEL_W-1:0] next_level;
  logic step;
  logic [PERIOD_W-1:0] step_period;

  wire wr_ctrl;
  wire wr_ad;
  wire wr_sr;
  wire key_rise;
  wire key_fall;
  wire [LEVEL_W-1:0] sustain_level;
  wire [3:0] rate_sel;
  wire fall;
  wire restart;
  wire at_peak;
  wire at_floor;
  wire at_sustain;
  wire [DATA_W-1:0] status_word;
  wire [DATA_W-1:0] next_rdata;

  assign wr_ctrl = reg_wr && (reg_addr == REG_CTRL);
  assign wr_ad = reg_wr && (reg_addr == REG_ATK_DCY);
  assign wr_sr = reg_wr && (reg_addr == REG_SUS_REL);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      key <= 1'b0;
    end else if (wr_ctrl) begin
      key <= reg_wdata[CTRL_KEY_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      settings <= {RESET_ATK_DCY, RESET_SUS_REL};
    end else begin
      if (wr_ad) begin
        settings.attack <= reg_wdata[7:4];
        settings.decay <= reg_wdata[3:0];
      end
      if (wr_sr) begin
        settings.sustain <= reg_wdata[7:4];
        settings.release_rate <= reg_wdata[3:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      key_prev <= 1'b0;
    end else begin
      key_prev <= key;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read port: data stands in the cycle after the strobe only
  assign status_word = {3'h0, key, 1'b0, state};
  assign next_rdata = !reg_rd ? 8'h00 :
                      (reg_addr == REG_CTRL) ? {7'h00, key} :
                      (reg_addr == REG_ATK_DCY) ? {settings.attack, settings.decay} :
                      (reg_addr == REG_SUS_REL) ? {settings.sustain, settings.release_rate} :
                      (reg_addr == REG_LEVEL) ? env_level :
                      (reg_addr == REG_STATUS) ? status_word : 8'h00;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // rate selection and step timing
  assign key_rise = key && !key_prev;
  assign key_fall = !key && key_prev;
  assign sustain_level = LEVEL_W'(settings.sustain) * SUSTAIN_SCALE;
  // own setting for attack and decay; every other phase uses the release setting
  // rate follows the phase about to run, so a new phase never times off a stale period
  assign rate_sel = (next_state == ADSR_ATTACK) ? settings.attack :
                    (next_state == ADSR_DECAY) ? settings.decay : settings.release_rate;
  assign fall = (next_state != ADSR_ATTACK);
  assign restart = (next_state != state) || key_rise;
  assign at_peak = (env_level == LEVEL_MAX);
  assign at_floor = (env_level == LEVEL_MIN);
  assign at_sustain = (env_level <= sustain_level);

  adsr_rate_table #(
    .TIME_DIV(TIME_DIV)
  ) u_rate (
    .ref_clk(ref_clk),
    .srst(srst),
    .rate_sel(rate_sel),
    .fall(fall),
    .step_period(step_period)
  );

  adsr_step_timer u_timer (
    .ref_clk(ref_clk),
    .srst(srst),
    .restart(restart),
    .step_period(step_period),
    .step(step)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // phase sequencing
  always_comb begin
    next_state = state;
    if (key_rise) begin
      next_state = ADSR_ATTACK;
    end else if (!key && state != ADSR_IDLE && state != ADSR_RELEASE) begin
      next_state = ADSR_RELEASE;
    end else begin
      case (state)
        ADSR_IDLE: begin
          next_state = ADSR_IDLE;
        end
        ADSR_ATTACK: begin
          if (at_peak) begin
            next_state = ADSR_DECAY;
          end
        end
        ADSR_DECAY: begin
          if (at_sustain) begin
            next_state = ADSR_SUSTAIN;
          end
        end
        ADSR_SUSTAIN: begin
          next_state = ADSR_SUSTAIN;
        end
        ADSR_RELEASE: begin
          if (at_floor) begin
            next_state = ADSR_IDLE;
          end
        end
        default: begin
          next_state = ADSR_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    next_level = env_level;
    if (step && !restart) begin
      case (state)
        ADSR_ATTACK: next_level = env_level + LEVEL_W'(1);
        ADSR_DECAY: next_level = env_level - LEVEL_W'(1);
        ADSR_RELEASE: next_level = env_level - LEVEL_W'(1);
        default: next_level = env_level;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state <= ADSR_IDLE;
      env_level <= LEVEL_MIN;
    end else begin
      state <= next_state;
      env_level <= next_level;
    end
  end

  assign env_phase = state;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  // attack exit order
  property p_phase_order;
    @(posedge ref_clk) disable iff (srst)
      (state == ADSR_ATTACK && !key_rise && key) |=>
        (state == ADSR_ATTACK || state == ADSR_DECAY);
  endproperty
  a_phase_order: assert property (p_phase_order) else $error("attack left out of order");

  property p_peak_to_decay;
    @(posedge ref_clk) disable iff (srst)
      (state == ADSR_ATTACK && at_peak && key && !key_rise) |=> state == ADSR_DECAY;
  endproperty
  a_peak_to_decay: assert property (p_peak_to_decay) else $error("peak did not start decay");

  property p_sustain_hold;
    @(posedge ref_clk) disable iff (srst)
      (state == ADSR_SUSTAIN && key && !key_rise) |=>
        (state == ADSR_SUSTAIN && $stable(env_level));
  endproperty
  a_sustain_hold: assert property (p_sustain_hold) else $error("sustain not held");

  property p_zero_sustain;
    @(posedge ref_clk) disable iff (srst)
      (state == ADSR_SUSTAIN && $past(state) == ADSR_DECAY && $past(settings.sustain) == 4'h0)
        |-> env_level == LEVEL_MIN;
  endproperty
  a_zero_sustain: assert property (p_zero_sustain) else $error("zero sustain above zero");

  property p_decay_abandon;
    @(posedge ref_clk) disable iff (srst)
      (state == ADSR_DECAY && key_fall) |-> next_state == ADSR_RELEASE ##1
        (state == ADSR_RELEASE && rate_sel == settings.release_rate);
  endproperty
  a_decay_abandon: assert property (p_decay_abandon) else $error("decay not abandoned");

  property p_rise_restart;
    @(posedge ref_clk) disable iff (srst)
      key_rise |=> (state == ADSR_ATTACK && env_level == $past(env_level));
  endproperty
  a_rise_restart: assert property (p_rise_restart) else $error("attack not restarted");

  property p_release_falls;
    @(posedge ref_clk) disable iff (srst)
      (state == ADSR_RELEASE && step && !restart) |=> env_level == $past(env_level) - 8'h01;
  endproperty
  a_release_falls: assert property (p_release_falls) else $error("release step lost");

  property p_read_data;
    @(posedge ref_clk) disable iff (srst)
      (reg_rd && reg_addr == REG_LEVEL) |=> reg_rdata == $past(env_level);
  endproperty
  a_read_data: assert property (p_read_data) else $error("level read wrong");

  property p_attack_rises;
    @(posedge ref_clk) disable iff (srst)
      (state == ADSR_ATTACK && step && !restart) |=> env_level == $past(env_level) + 8'h01;
  endproperty
  a_attack_rises: assert property (p_attack_rises) else $error("attack step lost");

  property p_decay_falls;
    @(posedge ref_clk) disable iff (srst)
      (state == ADSR_DECAY && step && !restart) |=> env_level == $past(env_level) - 8'h01;
  endproperty
  a_decay_falls: assert property (p_decay_falls) else $error("decay step lost");

  property p_peak_hold;
    @(posedge ref_clk) disable iff (srst)
      (state == ADSR_ATTACK && at_peak) |=> env_level == LEVEL_MAX;
  endproperty
  a_peak_hold: assert property (p_peak_hold) else $error("level wrapped past peak");

  property p_level_step_one;
    @(posedge ref_clk) disable iff (srst)
      1'b1 |=> (env_level == $past(env_level) || env_level == $past(env_level) + 8'h01 ||
                env_level == $past(env_level) - 8'h01);
  endproperty
  a_level_step_one: assert property (p_level_step_one) else $error("level jumped");

  property p_idle_floor;
    @(posedge ref_clk) disable iff (srst)
      state == ADSR_IDLE |-> env_level == LEVEL_MIN;
  endproperty
  a_idle_floor: assert property (p_idle_floor) else $error("idle above zero");

  property p_decay_rate;
    @(posedge ref_clk) disable iff (srst)
      next_state == ADSR_DECAY |-> (rate_sel == settings.decay && fall);
  endproperty
  a_decay_rate: assert property (p_decay_rate) else $error("decay rate not selected");

  property p_sustain_entry;
    @(posedge ref_clk) disable iff (srst)
      (state == ADSR_DECAY && at_sustain && key && !key_rise) |=> state == ADSR_SUSTAIN;
  endproperty
  a_sustain_entry: assert property (p_sustain_entry) else $error("sustain not entered");

  property p_no_early_release;
    @(posedge ref_clk) disable iff (srst)
      (state == ADSR_SUSTAIN && key) |=> state != ADSR_RELEASE;
  endproperty
  a_no_early_release: assert property (p_no_early_release) else $error("early release");

  property p_release_on_clear;
    @(posedge ref_clk) disable iff (srst)
      (!key && (state == ADSR_ATTACK || state == ADSR_DECAY || state == ADSR_SUSTAIN))
        |=> state == ADSR_RELEASE;
  endproperty
  a_release_on_clear: assert property (p_release_on_clear) else $error("release not begun");

  property p_release_rate;
    @(posedge ref_clk) disable iff (srst)
      (state == ADSR_RELEASE && next_state == ADSR_RELEASE) |->
        (rate_sel == settings.release_rate && fall);
  endproperty
  a_release_rate: assert property (p_release_rate) else $error("release rate not used");

endmodule

//--- verilog/adsr_pkg.sv
package adsr_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register port
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 3'h0;
  localparam logic [ADDR_W-1:0] REG_ATK_DCY = 3'h1;
  localparam logic [ADDR_W-1:0] REG_SUS_REL = 3'h2;
  localparam logic [ADDR_W-1:0] REG_LEVEL = 3'h3;
  localparam logic [ADDR_W-1:0] REG_STATUS = 3'h4;
  localparam int CTRL_KEY_BIT = 0;
  localparam logic [DATA_W-1:0] RESET_ATK_DCY = 8'h00;
  localparam logic [DATA_W-1:0] RESET_SUS_REL = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // envelope
  localparam int LEVEL_W = 8;
  localparam logic [LEVEL_W-1:0] LEVEL_MAX = 8'hff;
  localparam logic [LEVEL_W-1:0] LEVEL_MIN = 8'h00;
  localparam logic [LEVEL_W-1:0] SUSTAIN_SCALE = 8'h11;
  localparam int PERIOD_W = 24;

  typedef struct packed {
    logic [3:0] attack;
    logic [3:0] decay;
    logic [3:0] sustain;
    logic [3:0] release_rate;
  } adsr_settings_t;

  typedef enum logic [2:0] {
    ADSR_IDLE = 3'h0,
    ADSR_ATTACK = 3'h1,
    ADSR_DECAY = 3'h3,
    ADSR_SUSTAIN = 3'h2,
    ADSR_RELEASE = 3'h6
  } adsr_phase_t;

  ////////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_MHZ = 20;
  localparam int ATTACK0_US = 2000;
  localparam int DECAY9_US = 750000;
  localparam int RELEASE0_US = 6000;
  // decay and release ramps are three times slower than attack at equal setting
  localparam int FALL_MULT = 3;
  localparam int ATTACK0_STEP_CYC = ATTACK0_US * CLK_MHZ / 255;
  localparam int DECAY9_STEP_CYC = DECAY9_US * CLK_MHZ / 255;
  localparam int RELEASE0_STEP_CYC = RELEASE0_US * CLK_MHZ / 255;

  // full-scale attack time per setting, microseconds
  function automatic int adsr_attack_us(input logic [3:0] sel);
    case (sel)
      4'h0: return ATTACK0_US;
      4'h1: return 8000;
      4'h2: return 16000;
      4'h3: return 24000;
      4'h4: return 38000;
      4'h5: return 56000;
      4'h6: return 68000;
      4'h7: return 80000;
      4'h8: return 100000;
      4'h9: return DECAY9_US / FALL_MULT;
      4'ha: return 500000;
      4'hb: return 800000;
      4'hc: return 1000000;
      4'hd: return 3000000;
      4'he: return 5000000;
      default: return 8000000;
    endcase
  endfunction

endpackage

//--- verilog/adsr_rate_table.sv
`timescale 1ns/1ps
module adsr_rate_table #(
  parameter int TIME_DIV = 1
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [3:0] rate_sel,
  input wire logic fall,
  output logic [adsr_pkg::PERIOD_W-1:0] step_period
);
  import adsr_pkg::*;

  // expected periods at this divider, floored at one cycle like the hardware
  localparam int ATK0_EXP = (ATTACK0_STEP_CYC / TIME_DIV > 0) ?
                            ATTACK0_STEP_CYC / TIME_DIV : 1;
  localparam int DCY9_EXP = (DECAY9_STEP_CYC / TIME_DIV > 0) ?
                            DECAY9_STEP_CYC / TIME_DIV : 1;
  localparam int REL0_EXP = (RELEASE0_STEP_CYC / TIME_DIV > 0) ?
                            RELEASE0_STEP_CYC / TIME_DIV : 1;

  wire [63:0] total_cyc;
  wire [63:0] raw_cyc;
  wire [PERIOD_W-1:0] next_period;

  // rate to period
  // step period = phase time spread over the 255 level steps
  assign total_cyc = 64'(adsr_attack_us(rate_sel)) * 64'(CLK_MHZ) *
                     (fall ? 64'(FALL_MULT) : 64'h1);
  assign raw_cyc = total_cyc / 64'(255 * TIME_DIV);
  // never below one cycle, even with a large divider
  assign next_period = (raw_cyc == 64'h0) ? PERIOD_W'(1) : raw_cyc[PERIOD_W-1:0];

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      step_period <= PERIOD_W'(ATTACK0_STEP_CYC);
    end else begin
      step_period <= next_period;
    end
  end

  property p_attack0_period;
    @(posedge ref_clk) disable iff (srst)
      (rate_sel == 4'h0 && !fall) |=>
        step_period == PERIOD_W'(ATK0_EXP);
  endproperty
  a_attack0_period: assert property (p_attack0_period) else $error("attack 0 period wrong");

  property p_decay9_period;
    @(posedge ref_clk) disable iff (srst)
      (rate_sel == 4'h9 && fall) |=>
        step_period == PERIOD_W'(DCY9_EXP);
  endproperty
  a_decay9_period: assert property (p_decay9_period) else $error("decay 9 period wrong");

  property p_release0_period;
    @(posedge ref_clk) disable iff (srst)
      (rate_sel == 4'h0 && fall) |=>
        step_period == PERIOD_W'(REL0_EXP);
  endproperty
  a_release0_period: assert property (p_release0_period) else $error("release 0 period wrong");

endmodule

//--- verilog/adsr_step_timer.sv
`timescale 1ns/1ps
module adsr_step_timer (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic restart,
  input wire logic [adsr_pkg::PERIOD_W-1:0] step_period,
  output logic step
);
  import adsr_pkg::*;

  logic [PERIOD_W-1:0] count;
  wire at_end;

  assign at_end = (count >= step_period - PERIOD_W'(1));

  always_ff @(posedge ref_clk) begin
    if (srst || restart || at_end) begin
      count <= '0;
    end else begin
      count <= count + PERIOD_W'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      step <= 1'b0;
    end else begin
      step <= at_end && !restart;
    end
  end

endmodule

//--- bench/adsr_envelope_generator_tb_top.sv
`timescale 1ns/1ps
module adsr_envelope_generator_tb_top;
  import adsr_pkg::*;
  // step periods shrink a hundredfold so the slow decay still fits the run
  localparam int TD = 100;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = 3'h0;
  logic [DATA_W-1:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic [LEVEL_W-1:0] env_level;
  adsr_phase_t env_phase;
  int error_cnt = 0;
  int checks_done = 0;
  int seed = 32'h8c43;
  int n;
  int lvl;
  logic [7:0] d;
  logic [7:0] w;
  logic [3:0] s;

  adsr_envelope_generator #(.TIME_DIV(TD)) dut_u (
    .ref_clk(ref_clk),
    .srst(srst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .env_level(env_level),
    .env_phase(env_phase)
  );

  initial begin
    forever #25 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic int step_cyc(input int us);
    int p;
    p = us * CLK_MHZ / (255 * TD);
    return (p < 1) ? 1 : p;
  endfunction

  // first step lands a period plus a cycle or two after the phase change
  function automatic bit near(input int got, input int exp);
    return (got >= exp - 2) && (got <= exp + 8);
  endfunction

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic wait_phase(input adsr_phase_t ph, input int bound, output int cnt);
    cnt = 0;
    #1;
    while (env_phase !== ph) begin
      @(posedge ref_clk);
      #1 cnt++;
      if (cnt > bound) begin
        error_cnt++;
        $display("unexpected phase expected %h seen %h", ph, env_phase);
        report_and_stop();
      end
    end
  endtask

  task automatic setup(input logic [3:0] a, input logic [3:0] dc, input logic [3:0] su,
                       input logic [3:0] re);
    wr(REG_ATK_DCY, {a, dc});
    wr(REG_SUS_REL, {su, re});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    rd(REG_ATK_DCY, d); chk("atk_dcy_reset", RESET_ATK_DCY, d);
    rd(REG_SUS_REL, d); chk("sus_rel_reset", RESET_SUS_REL, d);
    rd(REG_STATUS, d); chk("status_reset", {5'h0, ADSR_IDLE}, d);
    // read data stand one cycle only
    @(posedge ref_clk);
    #1 chk("rdata_clear", 8'h00, reg_rdata);
    // register port with random data, unmapped and read-only places
    for (int i = 0; i < 8; i++) begin
      w = 8'($random(seed));
      wr(3'(REG_ATK_DCY + i % 2), w);
      rd(3'(REG_ATK_DCY + i % 2), d);
      chk("settings_rw", w, d);
      wr(REG_CTRL, w & 8'hfe);
      rd(REG_CTRL, d); chk("ctrl_rw", 8'h00, d);
      wr(3'(5 + i % 3), w);
      rd(3'(5 + i % 3), d);
      chk("unmapped", 8'h00, d);
      wr(REG_LEVEL, w);
      rd(REG_LEVEL, d); chk("level_ro", 8'h00, d);
    end
    // full envelope, slow decay, random nonzero sustain
    s = 4'h8 + 4'($random(seed) & 7);
    setup(4'h0, 4'h9, s, 4'h0);
    wr(REG_CTRL, 8'h01);
    wait_phase(ADSR_ATTACK, 4, n);
    wait_phase(ADSR_DECAY, 600, n);
    chk("attack_time", 8'h01, near(n, 255 * step_cyc(ATTACK0_US)));
    chk("attack_peak", LEVEL_MAX, env_level);
    wait_phase(ADSR_SUSTAIN, 90000, n);
    chk("decay_time", 8'h01, near(n, (255 - s * 17) * step_cyc(DECAY9_US)));
    chk("sustain_level", s * 8'h11, env_level);
    repeat (300) @(posedge ref_clk);
    #1 chk("sustain_hold", s * 8'h11, env_level);
    chk("sustain_phase", ADSR_SUSTAIN, env_phase);
    rd(REG_STATUS, d); chk("status_sus", {3'h0, 1'b1, 1'b0, ADSR_SUSTAIN}, d);
    rd(REG_LEVEL, d); chk("level_reg", s * 8'h11, d);
    rd(REG_CTRL, d);
    chk("ctrl_key", 8'h01, d);
    // host leaves the envelope time to settle between toggles
    wr(REG_CTRL, 8'h00);
    wait_phase(ADSR_RELEASE, 4, n);
    wait_phase(ADSR_IDLE, 2000, n);
    chk("release_time", 8'h01, near(n, s * 17 * step_cyc(RELEASE0_US)));
    chk("release_end", LEVEL_MIN, env_level);
    // zero sustain: falls to zero and stays while key held
    setup(4'h0, 4'h0, 4'h0, 4'h9);
    wr(REG_CTRL, 8'h01);
    wait_phase(ADSR_DECAY, 600, n);
    n = 0;
    while (env_level !== LEVEL_MIN && n < 2000) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk("zero_decay_time", 8'h01, near(n, 255 * step_cyc(ATTACK0_US * FALL_MULT)));
    repeat (100) @(posedge ref_clk);
    #1 chk("zero_sustain_level", LEVEL_MIN, env_level);
    chk("zero_sustain_key", ADSR_SUSTAIN, env_phase);
    wr(REG_CTRL, 8'h00);
    wait_phase(ADSR_IDLE, 20, n);
    // key cleared mid decay: release rate takes over at once
    setup(4'h0, 4'h9, 4'h8, 4'h0);
    wr(REG_CTRL, 8'h01);
    wait_phase(ADSR_DECAY, 600, n);
    repeat (2000) @(posedge ref_clk);
    wr(REG_CTRL, 8'h00);
    wait_phase(ADSR_RELEASE, 3, n);
    lvl = env_level;
    wait_phase(ADSR_IDLE, 2000, n);
    chk("abandon_decay", 8'h01, near(n, lvl * step_cyc(RELEASE0_US)));
    // retrigger in release restarts attack from current level
    wr(REG_CTRL, 8'h01);
    wait_phase(ADSR_DECAY, 600, n);
    wr(REG_CTRL, 8'h00);
    wait_phase(ADSR_RELEASE, 3, n);
    repeat (200) @(posedge ref_clk);
    #1 lvl = env_level;
    wr(REG_CTRL, 8'h01);
    wait_phase(ADSR_ATTACK, 4, n);
    chk("restart_level", 8'h01, (env_level + 2 >= lvl) && (env_level <= lvl + 2));
    wait_phase(ADSR_DECAY, 600, n);
    chk("restart_attack", 8'h01, near(n, 255 - lvl));
    report_and_stop();
  end
endmodule
